// ---- bpe_pkg.sv ----
`default_nettype none
package bpe_pkg;
	// Register map
	localparam int         AXI_AW         = 8;
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_STAT      = 8'h04;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	// Control bits in the command word
	localparam int         CMD_SPEC_BIT   = 3;
	localparam int         CMD_PER_BIT    = 6;
	localparam int         CMD_SERR_BIT   = 8;
	// Status bits
	localparam int         ST_MDPE_BIT    = 8;
	localparam int         ST_DPE_BIT     = 15;
	localparam logic [15:0] CTRL_RST      = 16'h0000;
	// Bus command codes
	localparam logic [3:0] BUS_CMD_SPECIAL = 4'h1;
	localparam logic [3:0] BUS_CMD_DAC     = 4'hD;
	// Clock counts on the bus
	localparam logic [2:0] PERR_MIN_CLKS  = 3'h3;
	localparam logic [2:0] PERR_MIN_SLOW  = 3'h4;
	localparam logic [1:0] PERR_TAIL_CLKS = 2'h2;
	localparam logic [2:0] CNT_MAX        = 3'h7;

	typedef struct packed {
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        perr_n;
		logic        par;
		logic [3:0]  cbe_n;
		logic [31:0] ad;
	} bpe_bus_t;

	typedef struct packed {
		logic perr_o;
		logic perr_oe;
		logic serr_o;
		logic serr_oe;
	} bpe_pins_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_DAC,
		PH_DATA,
		PH_TAIL
	} bpe_phase_t;
endpackage
`default_nettype wire

// ---- bpe_parity_report.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module bpe_parity_report
	import bpe_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Bus pins, asynchronous to aclk
	input  wire bpe_bus_t          bus_i,
	output var  bpe_pins_t         pins_o,
	// Local bus engine, valid for a whole transaction
	input  wire logic              own_mst,
	input  wire logic              own_tgt,
	input  wire logic              slow_decode,
	input  wire logic              dev_sel,
	output logic                   mst_complete_req,
	output logic                   tgt_complete_req,
	output logic                   addr_fault_sel,
	output logic                   mst_wr_fault,
	output logic                   mst_wr_ok,
	// AXI4-Lite slave
	input  wire logic [AXI_AW-1:0] s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	input  wire logic [AXI_AW-1:0] s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and transaction tracking

	bpe_bus_t   sync1_r;
	bpe_bus_t   bus_r;
	bpe_phase_t ph_r;
	logic [3:0] cmd_r;
	logic [2:0] cnt_r;
	logic [1:0] tail_r;
	logic [15:0] ctrl_r;
	logic       per_en;
	logic       addr_ph;
	logic       is_wr;
	logic       is_spec;
	logic       rx_role;
	logic       dv;
	logic       comp;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_r <= '1;
			bus_r   <= '1;
		end
		else
		begin
			sync1_r <= bus_i;
			bus_r   <= sync1_r;
		end
	end

	assign per_en  = ctrl_r[CMD_PER_BIT];
	assign addr_ph = ((ph_r == PH_IDLE || ph_r == PH_TAIL) && !bus_r.frame_n) || ph_r == PH_DAC;
	assign is_wr   = cmd_r[0];
	assign is_spec = cmd_r == BUS_CMD_SPECIAL;
	assign rx_role = (own_tgt && is_wr) || (own_mst && !is_wr);
	assign dv      = ph_r == PH_DATA && (is_wr ? !bus_r.irdy_n : !bus_r.trdy_n);
	assign comp    = ph_r == PH_DATA && !bus_r.irdy_n && !bus_r.trdy_n;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ph_r   <= PH_IDLE;
			cmd_r  <= '0;
			cnt_r  <= '0;
			tail_r <= '0;
		end
		else
		begin
			case (ph_r)
				PH_IDLE, PH_TAIL:
				begin
					if (!bus_r.frame_n)
					begin
						cmd_r <= ~bus_r.cbe_n;
						cnt_r <= 3'h1;
						ph_r  <= (~bus_r.cbe_n == BUS_CMD_DAC) ? PH_DAC : PH_DATA;
					end
					else if (ph_r == PH_TAIL)
					begin
						tail_r <= tail_r - 2'h1;
						if (tail_r == 2'h1)
							ph_r <= PH_IDLE;
					end
				end
				PH_DAC:
				begin
					cmd_r <= ~bus_r.cbe_n;
					cnt_r <= 3'h1;
					ph_r  <= PH_DATA;
				end
				PH_DATA:
				begin
					if (cnt_r != CNT_MAX)
						cnt_r <= cnt_r + 3'h1;
					if (bus_r.frame_n && bus_r.irdy_n)
					begin
						ph_r   <= PH_TAIL;
						tail_r <= PERR_TAIL_CLKS;
					end
				end
				default:
					ph_r <= PH_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Parity check, one clock behind the covered phase

	logic [31:0] ad_q;
	logic [3:0]  cbe_q;
	logic        chk_q;
	logic        addr_q;
	logic        comp_q;
	logic        comp_c;
	logic        spec_q;
	logic        rd_q;
	logic        mis;
	logic        dbad;
	logic        abad;
	logic        bad_rep;
	logic        pend_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ad_q   <= '0;
			cbe_q  <= '0;
			chk_q  <= 1'b0;
			addr_q <= 1'b0;
			comp_q <= 1'b0;
			comp_c <= 1'b0;
			spec_q <= 1'b0;
			rd_q   <= 1'b0;
		end
		else
		begin
			ad_q   <= bus_r.ad;
			cbe_q  <= bus_r.cbe_n;
			chk_q  <= dv && (rx_role || is_spec);
			addr_q <= addr_ph;
			comp_q <= comp;
			comp_c <= comp_q;
			spec_q <= is_spec;
			rd_q   <= !is_wr;
		end
	end

	assign mis     = ^{ad_q, cbe_q, bus_r.par};
	assign dbad    = chk_q && mis;
	assign abad    = addr_q && mis;
	assign bad_rep = dbad && per_en && !spec_q;

	// Error seen before the data transfers keeps the line low until it does
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pend_r <= 1'b0;
		else if (ph_r != PH_DATA || comp_q)
			pend_r <= 1'b0;
		else if (bad_rep)
			pend_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers

	logic [2:0] min_clks;
	logic       drive_ok;
	logic       serr_trig;

	assign min_clks  = (own_tgt && slow_decode) ? PERR_MIN_SLOW : PERR_MIN_CLKS;
	// The pin register adds one clock, so the count is one short of the drive start
	assign drive_ok  = rx_role && !is_spec && ph_r == PH_DATA && cnt_r >= min_clks - 3'h1;
	assign serr_trig = ctrl_r[CMD_SERR_BIT] && per_en
		&& (abad || (dbad && spec_q && ctrl_r[CMD_SPEC_BIT]));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pins_o <= '{perr_o: 1'b1, perr_oe: 1'b0, serr_o: 1'b0, serr_oe: 1'b0};
		else
		begin
			pins_o.perr_o  <= !(bad_rep || pend_r);
			pins_o.perr_oe <= per_en && (drive_ok || (rx_role && ph_r == PH_TAIL));
			pins_o.serr_o  <= 1'b0;
			pins_o.serr_oe <= serr_trig && !pins_o.serr_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Indications to the local bus engine

	logic mst_wr;

	assign mst_wr = own_mst && is_wr && ph_r != PH_IDLE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mst_complete_req <= 1'b0;
			tgt_complete_req <= 1'b0;
			addr_fault_sel   <= 1'b0;
			mst_wr_fault     <= 1'b0;
			mst_wr_ok        <= 1'b0;
		end
		else
		begin
			mst_complete_req <= own_mst && (pend_r || (bad_rep && !comp_q));
			tgt_complete_req <= own_tgt && (pend_r || (bad_rep && !comp_q));
			addr_fault_sel   <= abad && per_en && dev_sel;
			mst_wr_fault     <= mst_wr && !bus_r.perr_n;
			mst_wr_ok        <= mst_wr && comp_c && bus_r.perr_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags

	logic mdpe_r;
	logic dpe_r;
	logic mdpe_set;
	logic dpe_set;
	logic mdpe_clr;
	logic dpe_clr;
	logic w_fire;

	assign mdpe_set = per_en && own_mst
		&& ((dbad && rd_q) || (mst_wr && !bus_r.perr_n));
	assign dpe_set  = abad || (dbad && !spec_q);
	assign w_fire   = s_awvalid && s_awready && s_wvalid && s_wready;
	assign mdpe_clr = w_fire && s_awaddr == ADDR_STAT && s_wstrb[1] && s_wdata[ST_MDPE_BIT];
	assign dpe_clr  = w_fire && s_awaddr == ADDR_STAT && s_wstrb[1] && s_wdata[ST_DPE_BIT];

	// A new error in the clearing cycle keeps its flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mdpe_r <= 1'b0;
			dpe_r  <= 1'b0;
		end
		else
		begin
			mdpe_r <= mdpe_set || (mdpe_r && !mdpe_clr);
			dpe_r  <= dpe_set || (dpe_r && !dpe_clr);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= RESP_OKAY;
			ctrl_r    <= CTRL_RST;
		end
		else
		begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			if (s_awvalid && s_wvalid && !s_awready && !s_bvalid)
			begin
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
			if (w_fire)
			begin
				s_bvalid <= 1'b1;
				s_bresp  <= (s_awaddr == ADDR_CTRL || s_awaddr == ADDR_STAT)
					? RESP_OKAY : RESP_SLVERR;
				if (s_awaddr == ADDR_CTRL)
				begin
					if (s_wstrb[0])
					begin
						ctrl_r[CMD_SPEC_BIT] <= s_wdata[CMD_SPEC_BIT];
						ctrl_r[CMD_PER_BIT]  <= s_wdata[CMD_PER_BIT];
					end
					if (s_wstrb[1])
						ctrl_r[CMD_SERR_BIT] <= s_wdata[CMD_SERR_BIT];
				end
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_arready <= 1'b0;
			if (s_arvalid && !s_arready && !s_rvalid)
				s_arready <= 1'b1;
			if (s_arvalid && s_arready)
			begin
				s_rvalid <= 1'b1;
				s_rdata  <= '0;
				s_rresp  <= RESP_OKAY;
				case (s_araddr)
					ADDR_CTRL:
						s_rdata <= {16'h0000, ctrl_r};
					ADDR_STAT:
					begin
						s_rdata[ST_MDPE_BIT] <= mdpe_r;
						s_rdata[ST_DPE_BIT]  <= dpe_r;
					end
					default:
						s_rresp <= RESP_SLVERR;
				endcase
			end
			else if (s_rvalid && s_rready)
				s_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ---- bpe_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module bpe_sva
	import bpe_pkg::*;
(
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Bus side
	input wire bpe_bus_t          bus_i,
	input wire bpe_pins_t         pins_o,
	input wire logic              addr_fault_sel,
	input wire logic              mst_wr_fault,
	input wire logic              mst_wr_ok,
	// Register bus
	input wire logic [AXI_AW-1:0] s_awaddr,
	input wire logic              s_awvalid,
	input wire logic              s_awready,
	input wire logic [31:0]       s_wdata,
	input wire logic [3:0]        s_wstrb,
	input wire logic [1:0]        s_bresp,
	input wire logic              s_bvalid,
	input wire logic              s_bready
);
	logic per_r;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////
	// Parity response enable as last written
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			per_r <= 1'h0;
		else if (s_awvalid && s_awready && s_awaddr == ADDR_CTRL && s_wstrb[0])
			per_r <= s_wdata[CMD_PER_BIT];
	end
	////////////////////////////////////////////////////////////
	a_serr_one_clk: assert property (pins_o.serr_oe |=> !pins_o.serr_oe)
		else $error("system fault pulse too long");
	a_serr_low: assert property (pins_o.serr_oe |-> !pins_o.serr_o)
		else $error("system fault not pulled low");
	a_perr_gate: assert property (!per_r |-> !pins_o.perr_oe)
		else $error("parity line driven with response off");
	a_serr_gate: assert property (!per_r |-> !pins_o.serr_oe)
		else $error("system fault with response off");
	a_perr_drive: assert property (!pins_o.perr_o |-> pins_o.perr_oe)
		else $error("parity error value not driven");
	a_perr_early: assert property ($fell(bus_i.frame_n) && !pins_o.perr_oe
		|=> !pins_o.perr_oe [*4]) else $error("parity line driven too early");
	a_wr_ok_pulse: assert property (mst_wr_ok |=> !mst_wr_ok)
		else $error("clean write indication too long");
	a_wr_excl: assert property (mst_wr_fault |-> !mst_wr_ok)
		else $error("write both clean and faulty");
	a_sel_pulse: assert property (addr_fault_sel |=> !addr_fault_sel)
		else $error("address fault indication too long");
	a_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response dropped");
	c_serr: cover property (pins_o.serr_oe);
	c_perr: cover property (pins_o.perr_oe && !pins_o.perr_o);
	c_wr_ok: cover property (mst_wr_ok);
endmodule
bind bpe_parity_report bpe_sva u_sva (.*);
`default_nettype wire

// ---- bpe_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module bpe_bus_model
	import bpe_pkg::*;
(
	// Clock
	input wire logic  aclk,
	// Bus
	input wire bpe_pins_t pins_i,
	output bpe_bus_t      bus_o
);
	bpe_bus_t b;
	logic     oth_perr;
	initial
	begin
		b = '1;
		oth_perr = 1'h0;
	end
	// Parity line resolves with a pull-up when nobody drives it
	always_comb
	begin
		bus_o = b;
		bus_o.perr_n = pins_i.perr_oe ? pins_i.perr_o : ~oth_perr;
	end
	////////////////////////////////////////////////////////////
	task automatic xfer(input logic [3:0] cmd, input logic ws, ba, bd, op);
		logic [31:0] d;
		d = 32'h5A5A1234;
		@(posedge aclk);
		b.frame_n <= 1'h0;
		b.ad <= 32'h00001000;
		b.cbe_n <= ~cmd;
		@(posedge aclk);
		// With ws the receiver holds off its ready for one clock
		b.frame_n <= ~(ws & ~cmd[0]);
		b.irdy_n <= ws & ~cmd[0];
		b.trdy_n <= ws & cmd[0];
		b.ad <= d;
		b.cbe_n <= 4'h0;
		b.par <= ^{32'h00001000, ~cmd} ^ ba;
		if (ws)
		begin
			@(posedge aclk);
			b.frame_n <= 1'h1;
			b.irdy_n <= 1'h0;
			b.trdy_n <= 1'h0;
			b.par <= ^{d, 4'h0} ^ bd;
		end
		@(posedge aclk);
		b.irdy_n <= 1'h1;
		b.trdy_n <= 1'h1;
		b.ad <= ~d;
		b.cbe_n <= 4'hF;
		b.par <= ^{d, 4'h0} ^ bd;
		@(posedge aclk);
		b.par <= ~b.par;
		oth_perr <= op;
		repeat (2) @(posedge aclk);
		oth_perr <= 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- bpe_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench
	import bpe_pkg::*;
;
	logic        aclk = 0, aresetn = 0, own_mst = 0, own_tgt = 0, slow_decode = 0, dev_sel = 0;
	logic        s_awvalid = 0, s_wvalid = 0, s_arvalid = 0, s_bready = 1, s_rready = 1;
	logic [7:0]  s_awaddr = '0, s_araddr = '0;
	logic [31:0] s_wdata = '0, s_rdata;
	logic [3:0]  s_wstrb = '0;
	logic [1:0]  s_bresp, s_rresp;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, clr = 0;
	logic        mst_complete_req, tgt_complete_req, addr_fault_sel, mst_wr_fault, mst_wr_ok;
	logic [6:0]  evt = '0;
	bpe_bus_t    bus_i;
	bpe_pins_t   pins_o;
	int          num_errors = 0, check_count = 0, cyc = 0;
	bpe_parity_report uut (.*);
	bpe_bus_model mdl (.aclk, .pins_i(pins_o), .bus_o(bus_i));
	always #10 aclk = ~aclk;
	always @(posedge aclk)
	begin
		// System fault is caught in the clock of its pulse, from its enable alone, and held until clr
		evt <= clr ? '0 : evt | {tgt_complete_req, mst_complete_req, mst_wr_ok, mst_wr_fault,
			addr_fault_sel, pins_o.serr_oe, pins_o.perr_oe & ~pins_o.perr_o};
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hF;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_awready === 1'h1)
				s_awvalid <= 1'h0;
			if (s_wready === 1'h1)
				s_wvalid <= 1'h0;
		end while (s_bvalid !== 1'h1);
		chk({30'h0, s_bresp}, {30'h0, er});
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_arready === 1'h1)
				s_arvalid <= 1'h0;
		end while (s_rvalid !== 1'h1);
		chk(s_rdata, ed);
		chk({30'h0, s_rresp}, {30'h0, er});
	endtask
	// One bus transaction, then events and status checked and status cleared
	task automatic run(input logic [3:0] c, input logic ws, ba, bd, op, m, t,
		input logic [6:0] ev, input logic [31:0] st);
		own_mst <= m;
		own_tgt <= t;
		dev_sel <= 1'h1;
		clr <= 1'h1;
		@(posedge aclk);
		clr <= 1'h0;
		mdl.xfer(c, ws, ba, bd, op);
		repeat (14) @(posedge aclk);
		own_mst <= 1'h0;
		own_tgt <= 1'h0;
		chk({25'h0, evt}, {25'h0, ev});
		axi_rd(ADDR_STAT, st, RESP_OKAY);
		axi_wr(ADDR_STAT, 32'h00008100, RESP_OKAY);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		axi_rd(ADDR_CTRL, 32'h0, RESP_OKAY);
		axi_rd(ADDR_STAT, 32'h0, RESP_OKAY);
		axi_rd(8'h08, 32'h0, RESP_SLVERR);
		axi_wr(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
		run(4'h6, 0, 0, 1, 0, 1, 0, 7'h00, 32'h8000);
		axi_wr(ADDR_CTRL, 32'h00000148, RESP_OKAY);
		axi_rd(ADDR_CTRL, 32'h00000148, RESP_OKAY);
		run(4'h7, 0, 0, 1, 0, 0, 1, 7'h01, 32'h8000);
		run(4'h7, 1, 0, 1, 0, 0, 1, 7'h41, 32'h8000);
		run(4'h6, 0, 0, 1, 0, 1, 0, 7'h01, 32'h8100);
		run(4'h6, 1, 0, 1, 0, 1, 0, 7'h21, 32'h8100);
		run(4'h6, 0, 0, 1, 0, 0, 1, 7'h00, 32'h0000);
		run(4'h7, 0, 0, 0, 1, 1, 0, 7'h08, 32'h0100);
		run(4'h7, 0, 0, 0, 0, 1, 0, 7'h10, 32'h0000);
		run(4'h7, 0, 1, 0, 0, 0, 1, 7'h06, 32'h8000);
		run(4'h1, 0, 0, 1, 0, 0, 0, 7'h02, 32'h0000);
		axi_wr(ADDR_CTRL, 32'h00000040, RESP_OKAY);
		run(4'h7, 0, 1, 0, 0, 0, 1, 7'h04, 32'h8000);
		test_done();
	end
endmodule
`default_nettype wire
